// [panel_mux_pkg.sv]
// shared constants for the panel output stage
package panel_mux_pkg;
    typedef enum logic [1:0] {
        WIDTH_24 = 2'b00,
        WIDTH_RSVD = 2'b01,
        WIDTH_16 = 2'b10,
        WIDTH_GPIO = 2'b11
    } bus_width_t;
    localparam int PIXEL_LINES = 24;
    localparam int PORT_BITS = 8;
    localparam int FIFO_DEPTH = 2;
    // configuration register 00h, flat link force bit position
    localparam logic [7:0] CFG_REG_OFFSET = 8'h00;
    localparam int FLAT_LINK_BIT = 1;
    // pixel pll default output, kHz
    localparam int PIXEL_PLL_DEFAULT_KHZ = 36000;
    // core clock rate, kHz
    localparam int CORE_CLK_KHZ = 200000;
    localparam logic [23:0] LINES_RESET = 24'h00_0000;
endpackage : panel_mux_pkg

// [pixel_stream_if.sv]
// pixel word handshake carrier between core side and link side
`timescale 1ns/1ps
interface pixel_stream_if #(parameter int WIDTH = 26);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : pixel_stream_if

// [pixel_cdc_fifo.sv]
// two-entry async fifo with gray pointers
`timescale 1ns/1ps
module pixel_cdc_fifo #(
    parameter int WIDTH = 26
) (
    input wire logic i_wr_clk,
    input wire logic i_wr_resetn,
    input wire logic i_rd_clk,
    input wire logic i_rd_resetn,
    pixel_stream_if.sink wr,
    pixel_stream_if.source rd
);
    // refuse a word width the storage cannot hold
    if (WIDTH < 1) begin : g_bad_width
        $error("pixel word width must be positive");
    end
    // -----------------------------------------------
    // storage and pointers
    // -----------------------------------------------
    logic [WIDTH-1:0] mem [0:1];
    logic [1:0] wptr, rptr;
    logic [1:0] rptr_s1, rptr_s2, wptr_s1, wptr_s2;
    logic [1:0] wbin, rbin;
    wire [1:0] rbin_s = {rptr_s2[1], rptr_s2[1] ^ rptr_s2[0]};
    wire [1:0] wbin_s = {wptr_s2[1], wptr_s2[1] ^ wptr_s2[0]};
    wire is_full = (wbin[1] != rbin_s[1]) && (wbin[0] == rbin_s[0]);
    wire is_empty = (rbin == wbin_s);
    wire do_wr = wr.valid && !is_full;
    wire do_rd = rd.ready && !is_empty;
    wire [1:0] wbin_nx = wbin + 2'd1;
    wire [1:0] rbin_nx = rbin + 2'd1;
    assign wr.ready = !is_full;
    assign rd.valid = !is_empty;
    assign rd.data = mem[rbin[0]];
    assign wptr = {wbin[1], wbin[1] ^ wbin[0]};
    assign rptr = {rbin[1], rbin[1] ^ rbin[0]};

    // write side pointer and storage
    always_ff @(posedge i_wr_clk or negedge i_wr_resetn) begin
        if (!i_wr_resetn) begin
            wbin <= 2'b00;
        end else if (do_wr) begin
            wbin <= wbin_nx;
        end
    end
    always_ff @(posedge i_wr_clk) begin
        if (do_wr) begin
            mem[wbin[0]] <= wr.data;
        end
    end
    // read pointer into write domain
    always_ff @(posedge i_wr_clk or negedge i_wr_resetn) begin
        if (!i_wr_resetn) begin
            rptr_s1 <= 2'b00;
            rptr_s2 <= 2'b00;
        end else begin
            rptr_s1 <= rptr;
            rptr_s2 <= rptr_s1;
        end
    end
    // read side pointer
    always_ff @(posedge i_rd_clk or negedge i_rd_resetn) begin
        if (!i_rd_resetn) begin
            rbin <= 2'b00;
        end else if (do_rd) begin
            rbin <= rbin_nx;
        end
    end
    // write pointer into read domain
    always_ff @(posedge i_rd_clk or negedge i_rd_resetn) begin
        if (!i_rd_resetn) begin
            wptr_s1 <= 2'b00;
            wptr_s2 <= 2'b00;
        end else begin
            wptr_s1 <= wptr;
            wptr_s2 <= wptr_s1;
        end
    end

    // words held, seen from the write side, never exceed the two entries
    chk_no_overflow: assert property (@(posedge i_wr_clk) disable iff (!i_wr_resetn)
        2'(wbin - rbin_s) != 2'h3) else $error("fifo holds more words than entries");
endmodule : pixel_cdc_fifo

// [rgb_panel_output_mux.sv]
// panel output stage: pixel steering, sync and serializer control
`timescale 1ns/1ps
module rgb_panel_output_mux #(
    parameter int PIXEL_CLK_KHZ = panel_mux_pkg::PIXEL_PLL_DEFAULT_KHZ
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_pixel_clk,
    input wire logic [1:0] i_bus_width,
    input wire logic i_flat_link_force,
    input wire logic i_serializer_enable,
    input wire logic i_pixel_valid,
    input wire logic [23:0] i_pixel_rgb,
    input wire logic i_hsync,
    input wire logic i_vsync,
    output logic o_pixel_ready,
    input wire logic [7:0] i_general_port_d_out,
    input wire logic [7:0] i_general_port_e_out,
    input wire logic [7:0] i_general_port_f_out,
    input wire logic [23:0] i_gpio_oe,
    input wire logic [23:0] i_panel_pixel_lines_in,
    output logic [23:0] o_panel_pixel_lines,
    output logic [23:0] o_panel_pixel_lines_oe,
    output logic [7:0] o_general_port_d_in,
    output logic [7:0] o_general_port_e_in,
    output logic [7:0] o_general_port_f_in,
    output logic o_pixel_clk,
    output logic o_panel_pixel_valid,
    output logic o_hsync_or_pd,
    output logic o_vsync_or_pd_n
);
    // -----------------------------------------------
    // elaboration checks
    // -----------------------------------------------
    if (PIXEL_CLK_KHZ <= 0 || PIXEL_CLK_KHZ > 100000) begin : g_bad_rate
        $error("pixel clock rate out of range");
    end

    // -----------------------------------------------
    // core side: pack word and buffer it
    // -----------------------------------------------
    pixel_stream_if #(.WIDTH(26)) core_side ();
    pixel_stream_if #(.WIDTH(26)) link_side ();
    assign core_side.valid = i_pixel_valid;
    assign core_side.data = {i_hsync, i_vsync, i_pixel_rgb};
    assign o_pixel_ready = core_side.ready;

    // link domain reset release, synchronised
    logic prst_s1, prst_n;
    always_ff @(posedge i_pixel_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prst_s1 <= 1'b0;
            prst_n <= 1'b0;
        end else begin
            prst_s1 <= 1'b1;
            prst_n <= prst_s1;
        end
    end

    pixel_cdc_fifo #(.WIDTH(26)) u_fifo (
        .i_wr_clk(i_core_clk),
        .i_wr_resetn(i_resetn),
        .i_rd_clk(i_pixel_clk),
        .i_rd_resetn(prst_n),
        .wr(core_side.sink),
        .rd(link_side.source)
    );
    // pixel side drains one word per pixel clock
    assign link_side.ready = 1'b1;

    // -----------------------------------------------
    // configuration synchronised into link domain
    // -----------------------------------------------
    logic [3:0] cfg_s1, cfg_s2;
    always_ff @(posedge i_pixel_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_s1 <= 4'h0;
            cfg_s2 <= 4'h0;
        end else begin
            cfg_s1 <= {i_serializer_enable, i_flat_link_force, i_bus_width};
            cfg_s2 <= cfg_s1;
        end
    end
    wire [1:0] width_cfg = cfg_s2[1:0];
    wire flat_link_force = cfg_s2[2];
    wire ser_enable = cfg_s2[3];

    // -----------------------------------------------
    // general purpose outputs synchronised into link domain
    // -----------------------------------------------
    // port values and enables come from the core side, so two flops first
    logic [23:0] gpo_s1, gpo_s2, goe_s1, goe_s2;
    always_ff @(posedge i_pixel_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gpo_s1 <= 24'h00_0000;
            gpo_s2 <= 24'h00_0000;
            goe_s1 <= 24'h00_0000;
            goe_s2 <= 24'h00_0000;
        end else begin
            gpo_s1 <= {i_general_port_d_out, i_general_port_e_out, i_general_port_f_out};
            gpo_s2 <= gpo_s1;
            goe_s1 <= i_gpio_oe;
            goe_s2 <= goe_s1;
        end
    end
    wire [7:0] port_d = gpo_s2[23:16];
    wire [7:0] port_e = gpo_s2[15:8];
    wire [7:0] port_f = gpo_s2[7:0];

    // -----------------------------------------------
    // line mapping
    // -----------------------------------------------
    wire [7:0] red = link_side.data[23:16];
    wire [7:0] green = link_side.data[15:8];
    wire [7:0] blue = link_side.data[7:0];
    wire word_hs = link_side.data[25];
    wire word_vs = link_side.data[24];
    // 24-bit layout
    wire [23:0] map_24 = {red, green, blue};
    // 16-bit layout, spare lines carry port d
    wire [23:0] map_16 = {red[4:0], port_d[7], port_d[5], port_d[4],
        green[5:0], port_d[3], port_d[2],
        blue[4:0], port_d[6], port_d[1], port_d[0]};
    // all lines general purpose
    wire [23:0] map_gp = {port_f[7:3], port_d[7], port_d[5],
        port_d[4], port_f[2:0], port_e[7:5],
        port_d[3], port_d[2], port_e[4:0],
        port_d[6], port_d[1], port_d[0]};
    // lines that are general purpose in 16-bit mode
    localparam logic [23:0] SPARE_16 = 24'h07_0307;
    wire is_24 = (width_cfg == panel_mux_pkg::WIDTH_24) || (width_cfg == panel_mux_pkg::WIDTH_RSVD);
    wire is_16 = (width_cfg == panel_mux_pkg::WIDTH_16);
    wire [23:0] gp_mask = is_24 ? 24'h00_0000 : (is_16 ? SPARE_16 : 24'hFF_FFFF);
    wire [23:0] pix_val = link_side.valid ? (is_24 ? map_24 : map_16) : 24'h00_0000;
    wire [23:0] next_lines = (pix_val & ~gp_mask) | ((is_16 ? map_16 : map_gp) & gp_mask);
    wire [23:0] next_oe = ~gp_mask | (gp_mask & goe_s2);
    wire next_de = link_side.valid && (width_cfg != panel_mux_pkg::WIDTH_GPIO);
    // without flat link force, sync levels ride with their word and hold between words
    wire next_hs = flat_link_force ? !ser_enable : (link_side.valid ? word_hs : o_hsync_or_pd);
    wire next_vs = flat_link_force ? ser_enable : (link_side.valid ? word_vs : o_vsync_or_pd_n);

    // -----------------------------------------------
    // outputs launched on falling pixel clock edge
    // -----------------------------------------------
    logic pf_rst_n;
    always_ff @(negedge i_pixel_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pf_rst_n <= 1'b0;
        end else begin
            pf_rst_n <= prst_n;
        end
    end
    // reset released on a falling edge, so the outputs first launch on the next falling edge
    always_ff @(negedge i_pixel_clk or negedge pf_rst_n) begin
        if (!pf_rst_n) begin
            o_panel_pixel_lines <= panel_mux_pkg::LINES_RESET;
            o_panel_pixel_lines_oe <= 24'h00_0000;
            o_panel_pixel_valid <= 1'b0;
            o_hsync_or_pd <= 1'b0;
            o_vsync_or_pd_n <= 1'b0;
        end else begin
            o_panel_pixel_lines <= next_lines;
            o_panel_pixel_lines_oe <= next_oe;
            o_panel_pixel_valid <= next_de;
            o_hsync_or_pd <= next_hs;
            o_vsync_or_pd_n <= next_vs;
        end
    end

    // pixel pll clock forwarded directly, never the core clock
    assign o_pixel_clk = i_pixel_clk;

    // -----------------------------------------------
    // general purpose inputs, two flops into core domain
    // -----------------------------------------------
    logic [23:0] pin_s1, pin_s2;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_s1 <= 24'h00_0000;
            pin_s2 <= 24'h00_0000;
        end else begin
            pin_s1 <= i_panel_pixel_lines_in;
            pin_s2 <= pin_s1;
        end
    end
    assign o_general_port_d_in = {pin_s2[18], pin_s2[2], pin_s2[17], pin_s2[16],
        pin_s2[9], pin_s2[8], pin_s2[1], pin_s2[0]};
    assign o_general_port_e_in = {pin_s2[12:10], pin_s2[7:3]};
    assign o_general_port_f_in = {pin_s2[23:19], pin_s2[15:13]};

    // -----------------------------------------------
    // checks
    // -----------------------------------------------
    chk_de_follows_word: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (link_side.valid && width_cfg != 2'b11) |=> o_panel_pixel_valid) else $error("de missed word");
    chk_de_low_idle: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        !link_side.valid |=> !o_panel_pixel_valid) else $error("de high without word");
    chk_de_off_gp: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (width_cfg == 2'b11) |=> !o_panel_pixel_valid) else $error("de high in gpio width");
    chk_red_24: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (link_side.valid && width_cfg == 2'b00) |=> o_panel_pixel_lines[23:16] == $past(red))
        else $error("red misplaced");
    chk_oe_full_24: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (width_cfg == 2'b00) |=> o_panel_pixel_lines_oe == 24'hFF_FFFF)
        else $error("24-bit lines not all driven");
    chk_green_16: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (link_side.valid && width_cfg == 2'b10) |=> o_panel_pixel_lines[15:10] == $past(green[5:0]))
        else $error("green misplaced");
    chk_blue_16: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (link_side.valid && width_cfg == 2'b10) |=> o_panel_pixel_lines[7:3] == $past(blue[4:0]))
        else $error("blue misplaced");
    chk_portd_16: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (width_cfg == 2'b10) |=> o_panel_pixel_lines[2] == $past(port_d[6]))
        else $error("port d line 2 wrong");
    chk_portf_gp: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        (width_cfg == 2'b11) |=> o_panel_pixel_lines[15:13] == $past(port_f[2:0]))
        else $error("port f low bits wrong");
    chk_vsync_pd: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        flat_link_force |=> o_vsync_or_pd_n == $past(ser_enable)) else $error("vsync pd wrong");
    chk_hsync_pd: assert property (@(negedge i_pixel_clk) disable iff (!pf_rst_n)
        flat_link_force |=> o_hsync_or_pd != $past(ser_enable)) else $error("hsync pd wrong");
    chk_pclk_source: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_pixel_clk == i_pixel_clk) else $error("pixel clock not forwarded");
endmodule : rgb_panel_output_mux

// [panel_model.sv]
// panel side model: records each word shown with data enable
`timescale 1ns/1ps
module panel_model (
    input wire logic i_pixel_clk,
    input wire logic [23:0] i_lines,
    input wire logic i_valid,
    input wire logic i_hsync_or_pd,
    input wire logic i_vsync_or_pd_n
);
    logic [25:0] seen_q[$];
    int late_count = 0;
    // ---------------------------------------------
    // capture at the panel's rising sample edge
    // ---------------------------------------------
    always @(posedge i_pixel_clk) begin
        if (i_valid === 1'b1) begin
            seen_q.push_back({i_hsync_or_pd, i_vsync_or_pd_n, i_lines});
        end
    end
    // lines moving while the clock is high risk a bad sample
    always @(i_lines) begin
        if (i_pixel_clk === 1'b1) begin
            late_count++;
        end
    end
endmodule : panel_model

// [tb_top.sv]
// self-checking bench for the panel output stage
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, pclk = 0, resetn, valid = 0, hs = 0, vs = 0, force_on = 0, ser_en = 0;
    logic [1:0] width = 0;
    logic [23:0] rgb = 0, goe = 0, ext = 0, pins, lines, oe;
    logic [7:0] pd = 0, pe = 0, pf = 0, d_in, e_in, f_in;
    logic ready, pclk_out, de, hpin, vpin, saw_full = 0;
    logic [25:0] exp_q[$];
    int fail_count = 0, num_checks = 0, seed = 32'h3078;
    // undriven lines show the bench's own level
    assign pins = (oe & lines) | (~oe & ext);
    rgb_panel_output_mux i_dut (.i_core_clk(clk), .i_resetn(resetn), .i_pixel_clk(pclk),
        .i_bus_width(width), .i_flat_link_force(force_on), .i_serializer_enable(ser_en),
        .i_pixel_valid(valid), .i_pixel_rgb(rgb), .i_hsync(hs), .i_vsync(vs), .o_pixel_ready(ready),
        .i_general_port_d_out(pd), .i_general_port_e_out(pe), .i_general_port_f_out(pf),
        .i_gpio_oe(goe), .i_panel_pixel_lines_in(pins), .o_panel_pixel_lines(lines),
        .o_panel_pixel_lines_oe(oe), .o_general_port_d_in(d_in), .o_general_port_e_in(e_in),
        .o_general_port_f_in(f_in), .o_pixel_clk(pclk_out), .o_panel_pixel_valid(de),
        .o_hsync_or_pd(hpin), .o_vsync_or_pd_n(vpin));
    panel_model i_panel (.i_pixel_clk(pclk_out), .i_lines(lines), .i_valid(de),
        .i_hsync_or_pd(hpin), .i_vsync_or_pd_n(vpin));
    // ---------------------------------------------
    // clocks: core 5 ns, link 125 ns with own phase
    // ---------------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #37;
        forever #62.5 pclk = ~pclk;
    end
    // ---------------------------------------------
    // expectations
    // ---------------------------------------------
    function automatic logic [23:0] gp(input logic [7:0] d, input logic [7:0] e, input logic [7:0] f);
        return {f[7:3], d[7], d[5], d[4], f[2:0], e[7:5], d[3], d[2], e[4:0], d[6], d[1], d[0]};
    endfunction : gp
    function automatic logic [23:0] ungp(input logic [23:0] w);
        return {w[18], w[2], w[17], w[16], w[9], w[8], w[1], w[0], w[12:10], w[7:3], w[23:19], w[15:13]};
    endfunction : ungp
    function automatic logic [25:0] expect_word(input logic [23:0] c, input logic h, input logic v);
        logic [23:0] p;
        p = c;
        if (width == 2'b10) begin
            p = {c[20:16], 3'h0, c[13:8], 2'h0, c[4:0], 3'h0} | (gp(pd, pe, pf) & 24'h07_0307);
        end
        return force_on ? {~ser_en, ser_en, p} : {h, v, p};
    endfunction : expect_word
    // ---------------------------------------------
    // tasks
    // ---------------------------------------------
    task automatic check(input string name, input logic [25:0] exp, input logic [25:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // back to back words, holding each until taken
    task automatic send(input int n);
        logic [23:0] c;
        logic h, v;
        for (int k = 0; k < n; k++) begin
            c = (k == 0) ? 24'hff_ffff : 24'($random(seed));
            h = 1'($random(seed));
            v = 1'($random(seed));
            valid <= 1'b1;
            rgb <= c;
            hs <= h;
            vs <= v;
            @(posedge clk);
            while (ready !== 1'b1) begin
                saw_full = 1'b1;
                @(posedge clk);
            end
            exp_q.push_back(expect_word(c, h, v));
        end
        valid <= 1'b0;
    endtask : send
    task automatic drain(input string name);
        repeat (200) if (i_panel.seen_q.size() < exp_q.size()) @(posedge pclk);
        repeat (4) @(posedge pclk);
        check("word count", 26'(exp_q.size()), 26'(i_panel.seen_q.size()));
        while (exp_q.size() > 0 && i_panel.seen_q.size() > 0) begin
            check(name, exp_q.pop_front(), i_panel.seen_q.pop_front());
        end
        exp_q.delete();
        i_panel.seen_q.delete();
    endtask : drain
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        // falling edge at time zero resets both clock domains at once
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        check("reset", 26'h000_0000, {1'b0, de, lines});
        check("pll default", 26'h000_8CA0, 26'(i_dut.PIXEL_CLK_KHZ));
        resetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            #1;
            check("pixel clock high", 26'(pclk), 26'(pclk_out));
            @(negedge pclk);
            #1;
            check("pixel clock low", 26'(pclk), 26'(pclk_out));
        end
        // widths 00, 01, 10, first free then forced
        for (int m = 0; m < 6; m++) begin
            @(posedge clk);
            width <= (m % 3 == 2) ? 2'b10 : 2'(m % 3);
            force_on <= 1'(m >= 3);
            ser_en <= 1'($random(seed));
            pd <= 8'($random(seed));
            pe <= 8'($random(seed));
            pf <= 8'($random(seed));
            repeat (6) @(posedge pclk);
            @(posedge clk);
            send(6 + m);
            drain("word");
            check("line enable", {2'h0, (width == 2'b10) ? 24'hF8_FCF8 : 24'hFF_FFFF}, 26'(oe));
            $display("test width mode %0d done", m);
        end
        check("stall seen", 26'h000_0001, 26'(saw_full));
        // all lines general purpose, random directions
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            width <= 2'b11;
            goe <= 24'($random(seed));
            ext <= 24'($random(seed));
            pd <= 8'($random(seed));
            pe <= 8'($random(seed));
            pf <= 8'($random(seed));
            repeat (6) @(posedge pclk);
            check("gpio lines", {2'h0, gp(pd, pe, pf) & goe}, {1'b0, de, lines & goe});
            check("gpio enable", 26'(goe), 26'(oe));
            check("gpio input", 26'(ungp(pins)), 26'({d_in, e_in, f_in}));
            $display("test gpio pass %0d done", k);
        end
        check("late line change", 26'h000_0000, 26'(i_panel.late_count));
        stop_test();
    end
    // watchdog well beyond the expected run
    initial begin
        #200_000;
        fail_count++;
        stop_test();
    end
endmodule : tb_top
